// >>> tcpu_pkg.sv
// constants shared by the timer/capture/pwm channel and its dead-band stage
// assumes a single system clock of 10 MHz and a synchronous active-high reset
package tcpu_pkg;
  localparam int CNT_W = 16;
  localparam int DB_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [DB_W-1:0] DB_RESET = 8'h00;
  localparam logic PWM_IDLE = 1'b0;
  localparam logic MODE_HALT = 1'b0;
  localparam logic MODE_RELOAD = 1'b1;
endpackage

// >>> tcpu_deadband.sv
// dead-band generator: splits one pwm level into true and complement drive
// assumes i_level is registered by the caller; kill is applied downstream
`timescale 1ns/100ps
module tcpu_deadband #(
  parameter int DB_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic i_level,
  input wire logic [DB_W-1:0] i_dead,
  output logic o_true,
  output logic o_compl
);
  import tcpu_pkg::*;

  logic level_q;
  logic [DB_W-1:0] gap_q;

  // each edge of the level turns both outputs off, then the new side waits
  // for the gap before turning on, so the pair never overlaps
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_run) begin
      level_q <= PWM_IDLE;
      gap_q <= DB_RESET;
    end else if (i_level != level_q) begin
      level_q <= i_level;
      gap_q <= i_dead;
    end else if (gap_q != DB_RESET) begin
      gap_q <= gap_q - DB_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_run) begin
      o_true <= PWM_IDLE;
      o_compl <= PWM_IDLE;
    end else begin
      o_true <= level_q && (i_level == level_q) && (gap_q == DB_RESET);
      o_compl <= !level_q && (i_level == level_q) && (gap_q == DB_RESET);
    end
  end

  chk_no_overlap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !(o_true && o_compl)) else $error("true and complement both high");
endmodule

// >>> tcpu_channel.sv
// one timer/capture/pwm channel with dead-band pair and hardware kill
// assumes all inputs are synchronous to i_clk_sys; control bits are ports
`timescale 1ns/100ps
module tcpu_channel #(
  parameter int CNT_W = tcpu_pkg::CNT_W,
  parameter int DB_W = tcpu_pkg::DB_W
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_mode_reload,
  input wire logic [CNT_W-1:0] i_period,
  input wire logic [CNT_W-1:0] i_compare,
  input wire logic [DB_W-1:0] i_dead,
  input wire logic i_capture_evt,
  input wire logic i_kill,
  input wire logic i_kill_true_lvl,
  input wire logic i_kill_compl_lvl,
  output logic [CNT_W-1:0] o_count,
  output logic [CNT_W-1:0] o_capture,
  output logic o_capture_pulse,
  output logic o_period_pulse,
  output logic o_halted,
  output logic o_pwm,
  output logic o_pwm_compl
);
  import tcpu_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic halted_q;
  logic pwm_q;
  logic db_true;
  logic db_compl;
  logic at_period;

  assign at_period = (count_q == i_period);

  // counter; halt is sticky until the channel is disabled and re-enabled
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_enable) begin
      count_q <= CNT_RESET;
      halted_q <= 1'b0;
    end else if (halted_q) begin
      count_q <= count_q;
    end else if (at_period) begin
      if (i_mode_reload == MODE_RELOAD) begin
        count_q <= CNT_RESET;
      end else begin
        halted_q <= 1'b1;
      end
    end else begin
      count_q <= count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_period_pulse <= 1'b0;
      o_halted <= 1'b0;
      o_count <= CNT_RESET;
    end else begin
      o_period_pulse <= i_enable && !halted_q && at_period;
      o_halted <= halted_q;
      o_count <= count_q;
    end
  end

  // capture is taken only while enabled, so a stale event cannot load it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_capture <= CNT_RESET;
      o_capture_pulse <= 1'b0;
    end else begin
      o_capture_pulse <= i_enable && i_capture_evt;
      if (i_enable && i_capture_evt) begin
        o_capture <= count_q;
      end
    end
  end

  // duty: high while count is below compare
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_enable) begin
      pwm_q <= PWM_IDLE;
    end else begin
      pwm_q <= (count_q < i_compare);
    end
  end

  tcpu_deadband #(.DB_W(DB_W)) u_db (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_run(i_enable),
    .i_level(pwm_q),
    .i_dead(i_dead),
    .o_true(db_true),
    .o_compl(db_compl)
  );

  // kill bypasses counter state so outputs go safe on the next edge;
  // there is no latch: outputs resume once kill drops
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pwm <= PWM_IDLE;
      o_pwm_compl <= PWM_IDLE;
    end else if (i_kill) begin
      o_pwm <= i_kill_true_lvl;
      o_pwm_compl <= i_kill_compl_lvl;
    end else begin
      o_pwm <= db_true;
      o_pwm_compl <= db_compl;
    end
  end

  chk_kill_safe: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_kill |=> (o_pwm == $past(i_kill_true_lvl)) &&
      (o_pwm_compl == $past(i_kill_compl_lvl)))
    else $error("kill did not force safe levels");

  chk_capture_value: assert property (@(posedge i_clk_sys)
    disable iff (i_reset)
    (i_enable && i_capture_evt) |=> o_capture == $past(count_q))
    else $error("capture value wrong");

  chk_count_step: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_enable && !halted_q && !at_period) ##1 i_enable
    |-> count_q == $past(count_q) + CNT_W'(1))
    else $error("counter did not advance by one");

  chk_reload_zero: assert property (@(posedge i_clk_sys)
    disable iff (i_reset)
    (i_enable && !halted_q && at_period && i_mode_reload) ##1 i_enable
    |-> count_q == CNT_RESET)
    else $error("counter did not reload");

  chk_halt_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_enable && at_period && !i_mode_reload) ##1 i_enable [*2]
    |-> halted_q && $stable(count_q))
    else $error("counter did not halt");

  chk_duty_match: assert property (@(posedge i_clk_sys)
    disable iff (i_reset)
    i_enable ##1 i_enable |-> pwm_q == ($past(count_q) < $past(i_compare)))
    else $error("pwm level mismatches compare");

  chk_disabled_idle: assert property (@(posedge i_clk_sys)
    disable iff (i_reset)
    (!i_enable && !i_kill) ##1 (!i_enable && !i_kill)
    |=> !o_pwm && !o_pwm_compl)
    else $error("outputs active while disabled");

  chk_dead_gap: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_kill && $fell(o_pwm) && i_dead != DB_RESET) ##1 !i_kill
    |-> !o_pwm_compl)
    else $error("complement rose without dead gap");
endmodule

// >>> tcpu_gate_model.sv
// gate driver pair model: flags shoot-through, measures dead gaps
// assumes the pair is sampled on the system clock
`timescale 1ns/100ps
module tcpu_gate_model (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_hi,
  input wire logic i_lo,
  output logic o_overlap,
  output logic [7:0] o_gap_min
);
  logic [7:0] gap_q;
  logic armed_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_overlap <= 1'b0;
      o_gap_min <= 8'hff;
      gap_q <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      // the first turn-on after reset is not a transition of the pair
      armed_q <= armed_q | i_hi | i_lo;
      o_overlap <= o_overlap | (i_hi & i_lo);
      // saturate so a long idle never wraps into a short gap
      gap_q <= (i_hi | i_lo) ? 8'h00 : gap_q + {7'h00, ~&gap_q};
      if (armed_q && (i_hi | i_lo) && gap_q != 8'h00 && gap_q < o_gap_min)
      begin
        o_gap_min <= gap_q;
      end
    end
  end
endmodule

// >>> tb_top.sv
// self-checking bench for one timer/capture/pwm channel
// assumes the package, design and gate model files compile first
`timescale 1ns/100ps
module tb_top;
  import tcpu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, mode = MODE_HALT, evt = 1'b0;
  logic kill = 1'b0, kt = 1'b0, kc = 1'b0, p;
  logic [CNT_W-1:0] per = 16'h0003, cmp = 16'h0000, cnt, cap, prv;
  logic [DB_W-1:0] dead = 8'h00;
  logic cap_p, per_p, halted, pwm, pwmc, ovl;
  logic [7:0] gmin;
  int n_errors = 0, num_checks = 0, k;
  always #50 clk = ~clk;
  tcpu_channel i_tcpu_channel (.i_clk_sys(clk), .i_reset(rst),
    .i_enable(en), .i_mode_reload(mode), .i_period(per), .i_compare(cmp),
    .i_dead(dead), .i_capture_evt(evt), .i_kill(kill),
    .i_kill_true_lvl(kt), .i_kill_compl_lvl(kc), .o_count(cnt),
    .o_capture(cap), .o_capture_pulse(cap_p), .o_period_pulse(per_p),
    .o_halted(halted), .o_pwm(pwm), .o_pwm_compl(pwmc));
  tcpu_gate_model i_tcpu_gate_model (.i_clk_sys(clk), .i_reset(rst),
    .i_hi(pwm), .i_lo(pwmc), .o_overlap(ovl), .o_gap_min(gmin));
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] e);
    num_checks++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    cyc(2);
    @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk({pwm, pwmc, halted, cap_p, per_p}, 16'h0000);
    chk(cnt, CNT_RESET);
    $display("test reset done");
    @(posedge clk);
    en <= 1'b1;
    mode <= MODE_RELOAD;
    cyc(3);
    k = 0;
    prv = cnt;
    // compare of zero keeps the true output low all the way
    repeat (8) begin
      @(negedge clk);
      k += per_p;
      if (cnt > per || pwm !== 1'b0 || (cnt !== prv + 16'h1 && cnt !== 16'h0))
        k += 100;
      prv = cnt;
    end
    chk(k, 16'h0002);
    $display("test reload done");
    @(posedge clk);
    en <= 1'b0;
    per <= 16'h0005;
    mode <= MODE_HALT;
    @(posedge clk);
    en <= 1'b1;
    cyc(12);
    chk(halted, 1'b1);
    chk(cnt, 16'h0005);
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
    @(negedge clk);
    chk(cap_p, 1'b1);
    chk(cap, 16'h0005);
    $display("test halt capture done");
    // mid-run reset also clears the gate model's gap record
    @(posedge clk);
    rst <= 1'b1;
    en <= 1'b0;
    per <= 16'h0009;
    cmp <= 16'h0005;
    dead <= 8'h03;
    mode <= MODE_RELOAD;
    @(posedge clk);
    rst <= 1'b0;
    en <= 1'b1;
    cyc(20);
    k = 0;
    p = pwm;
    // ten whole periods hold exactly ten rising edges
    repeat (100) begin
      @(negedge clk);
      if (pwm === 1'b1 && p === 1'b0) k++;
      p = pwm;
    end
    chk(k, 16'h000a);
    chk(gmin, 16'h0004);
    chk(ovl, 1'b0);
    $display("test pwm dead band done");
    @(posedge clk);
    kill <= 1'b1;
    kt <= 1'b1;
    cyc(2);
    chk({pwm, pwmc}, 16'h0002);
    @(posedge clk);
    kt <= 1'b0;
    kc <= 1'b1;
    cyc(2);
    chk({pwm, pwmc}, 16'h0001);
    $display("test kill done");
    report_and_stop;
  end
endmodule
